/* File: design/serial_register_access_port_map.svh */
`ifndef SERIAL_REGISTER_ACCESS_PORT_MAP_SVH
`define SERIAL_REGISTER_ACCESS_PORT_MAP_SVH

// ==========================================================
// Frame geometry and control field positions
// ==========================================================
`define HEAD_LAST 4'd15
`define DATA_LAST 4'd7
`define DIR_BIT 5
`define HOLD_BIT 0

// ==========================================================
// Storage slots
// ==========================================================
`define SLOT_COUNT 43
`define SLOT_SETUP 6'd0
`define SLOT_MAKER_LO 6'd2
`define SLOT_MAKER_HI 6'd3
`define SLOT_USER 6'd4
`define SLOT_SYSREF 6'd8
`define SLOT_OSC_CAL 6'd23
`define SLOT_CAL_PROG 6'd28
`define RO_SLOT_MASK 43'h0001080010c

// ==========================================================
// Register offsets
// ==========================================================
`define SETUP_PRIMARY_OFS 15'h000
`define OPERATING_STATE_OFS 15'h002
`define MAKER_ID_OFS 15'h00c
`define USER_OPTIONS_OFS 15'h010
`define CLOCKING_FIRST_OFS 15'h029
`define CLOCKING_SECOND_OFS 15'h02a
`define CLOCKING_THIRD_OFS 15'h02b
`define SYSREF_WINDOW_OFS 15'h02c
`define FULL_SCALE_OFS 15'h030
`define POWER_SAVING_OFS 15'h037
`define TIMESTAMP_CTRL_OFS 15'h03b
`define PLL_REF_OUT_OFS 15'h03c
`define PLL_FB_VP_OFS 15'h03d
`define PLL_FB_N_OFS 15'h03e
`define PLL_OSC_CTRL_OFS 15'h03f
`define SERIALIZER_EMPH_OFS 15'h048
`define TRIGGER_OUT_OFS 15'h057
`define PLL_PIN_OVR_OFS 15'h058
`define OSC_FREQ_ADJ_OFS 15'h059
`define PLL_CAL_RESET_OFS 15'h05c
`define OSC_CAL_CTRL_OFS 15'h05d
`define OSC_CAL_STATUS_OFS 15'h05e
`define CAL_ENABLE_OFS 15'h061
`define CAL_SETUP_FIRST_OFS 15'h062
`define CAL_SETUP_SECOND_OFS 15'h065
`define CAL_AVERAGING_OFS 15'h068
`define CAL_PROGRESS_OFS 15'h06a
`define CAL_PIN_SETUP_OFS 15'h06b
`define CAL_SOFT_TRIGGER_OFS 15'h06c
`define CAL_BG_LOW_POWER_OFS 15'h06e
`define GAIN_DAC_ADJ_OFS 15'h07a
`define BANDGAP_ADJ_OFS 15'h07c
`define TERM_ADJ_A_OFS 15'h07e
`define TERM_ADJ_B_OFS 15'h07f
`define TERM_ADJ_C_OFS 15'h080
`define TERM_ADJ_D_OFS 15'h081
`define CONV_SRC_DELAY_OFS 15'h09a
`define SEL_DELAY_CAL_OFS 15'h09b
`define CONV_DITHER_OFS 15'h09d
`define LOW_BIT_OUT_OFS 15'h160
`define LINK_SUBSYS_EN_OFS 15'h200

// ==========================================================
// Reset values
// ==========================================================
`define RESET_ZERO 8'h00
`define FUSE_DEFAULT 8'h00
`define SETUP_PRIMARY_RST 8'h30
`define CLOCKING_FIRST_RST 8'h80
`define CLOCKING_THIRD_RST 8'h10
`define FULL_SCALE_RST 16'ha000
`define POWER_SAVING_RST 8'h4b
`define PLL_REF_OUT_RST 8'h01
`define PLL_FB_N_RST 8'h20
`define PLL_OSC_CTRL_RST 8'h4f
`define OSC_CAL_CTRL_RST 8'h40
`define CAL_ENABLE_RST 8'h01
`define CAL_SETUP_FIRST_RST 8'h01
`define CAL_SETUP_SECOND_RST 8'h01
`define CAL_AVERAGING_RST 8'h61
`define CAL_SOFT_TRIGGER_RST 8'h01
`define CAL_BG_LOW_POWER_RST 8'h88
`define LINK_SUBSYS_EN_RST 8'h01

`endif

/* File: design/serial_register_access_port_pkg.sv */
`include "serial_register_access_port_map.svh"

package serial_register_access_port_pkg;

  // ==========================================================
  // Types
  // ==========================================================
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_HEAD = 2'b01,
    PH_DATA = 2'b10
  } phase_e;

  typedef logic [14:0] reg_addr_t;
  typedef logic [7:0]  byte_t;
  typedef logic [`SLOT_COUNT-1:0][7:0] slot_bytes_t;

  typedef struct packed {
    logic sclk;
    logic sdi;
    logic port_select_low_n;
  } serial_in_s;

  typedef struct packed {
    logic sdo;
    logic sdo_oe;
  } serial_out_s;

  typedef struct packed {
    byte_t sysref_capture_window_status;
    byte_t osc_cal;
    byte_t cal_progress;
  } ro_status_s;

  typedef struct packed {
    phase_e      phase;
    logic [3:0]  cnt;
    logic        sclk;
    logic        rw;
    reg_addr_t   addr;
    logic [14:0] head;
    logic [6:0]  rx;
    logic [6:0]  tx;
    logic        load;
    serial_out_s pins;
  } frame_s;

endpackage

/* File: design/byte_store.sv */
`timescale 1ns/100ps
`include "serial_register_access_port_map.svh"

// ==========================================================
// Byte store for the mapped registers
// ==========================================================
module byte_store
  import serial_register_access_port_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  // Write port
  input  wire logic        we_i,
  input  wire logic [5:0]  slot_i,
  input  wire byte_t       data_i,
  // Stored bytes
  output slot_bytes_t      bytes_o
);

  typedef struct packed {
    slot_bytes_t mem;
  } store_s;

  // Reset image in slot order; wide registers keep the low byte first
  localparam byte_t RESET_TABLE [`SLOT_COUNT] = '{
    `SETUP_PRIMARY_RST, `RESET_ZERO, `RESET_ZERO, `RESET_ZERO,
    `RESET_ZERO, `CLOCKING_FIRST_RST, `RESET_ZERO, `CLOCKING_THIRD_RST,
    `RESET_ZERO, 8'(`FULL_SCALE_RST), 8'(`FULL_SCALE_RST >> 8),
    `POWER_SAVING_RST, `RESET_ZERO, `PLL_REF_OUT_RST, `RESET_ZERO,
    `PLL_FB_N_RST, `PLL_OSC_CTRL_RST, `RESET_ZERO, `RESET_ZERO,
    `RESET_ZERO, `FUSE_DEFAULT, `RESET_ZERO, `OSC_CAL_CTRL_RST,
    `RESET_ZERO, `CAL_ENABLE_RST, `CAL_SETUP_FIRST_RST,
    `CAL_SETUP_SECOND_RST, `CAL_AVERAGING_RST, `RESET_ZERO,
    `RESET_ZERO, `CAL_SOFT_TRIGGER_RST, `CAL_BG_LOW_POWER_RST,
    `FUSE_DEFAULT, `FUSE_DEFAULT, `FUSE_DEFAULT, `FUSE_DEFAULT,
    `FUSE_DEFAULT, `FUSE_DEFAULT, `FUSE_DEFAULT, `FUSE_DEFAULT,
    `FUSE_DEFAULT, `RESET_ZERO, `LINK_SUBSYS_EN_RST
  };

  store_s st_q;
  store_s st_d;

  // One byte per write; the caller has already screened the slot
  always_comb begin
    st_d = st_q;
    if (we_i) begin
      st_d.mem[slot_i] = data_i;
    end
  end

  // Synchronous reset loads the reset image
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      for (int i = 0; i < `SLOT_COUNT; i++) begin
        st_q.mem[i] <= RESET_TABLE[i];
      end
    end else begin
      st_q <= st_d;
    end
  end

  assign bytes_o = st_q.mem;

endmodule

/* File: design/serial_register_access_port.sv */
`timescale 1ns/100ps
`include "serial_register_access_port_map.svh"


// ==========================================================
// Serial register access port
// ==========================================================
module serial_register_access_port
  import serial_register_access_port_pkg::*;
#(
  parameter logic [15:0] MAKER_ID = 16'h5a3c  // Arbitrary value
) (
  // Clock and reset
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  // Serial pins
  input  wire serial_in_s  pins_i,
  output serial_out_s      pins_o,
  // Device status in, configuration out
  input  wire ro_status_s  status_i,
  output slot_bytes_t      cfg_o
);

  // ==========================================================
  // Declarations
  // ==========================================================
  frame_s      st_q;
  frame_s      st_d;
  slot_bytes_t bytes_w;
  logic        cs_hi_w;
  logic        rise_w;
  logic        fall_w;
  logic        byte_done_w;
  logic        dir_up_w;
  logic        hold_w;
  logic        wr_en_w;
  logic [6:0]  dec_w;
  logic [5:0]  wr_idx_w;
  byte_t       wr_data_w;
  byte_t       rd_data_w;
  reg_addr_t   next_addr_w;
  logic [15:0] hdr_w;

  localparam logic [`SLOT_COUNT-1:0] RO_MASK = `RO_SLOT_MASK;

  // Address of each slot; a wide register takes two slots, low byte first
  localparam reg_addr_t SLOT_OFS [`SLOT_COUNT] = '{
    `SETUP_PRIMARY_OFS,
    `OPERATING_STATE_OFS,
    `MAKER_ID_OFS,
    `MAKER_ID_OFS + 15'd1,
    `USER_OPTIONS_OFS,
    `CLOCKING_FIRST_OFS,
    `CLOCKING_SECOND_OFS,
    `CLOCKING_THIRD_OFS,
    `SYSREF_WINDOW_OFS,
    `FULL_SCALE_OFS,
    `FULL_SCALE_OFS + 15'd1,
    `POWER_SAVING_OFS,
    `TIMESTAMP_CTRL_OFS,
    `PLL_REF_OUT_OFS,
    `PLL_FB_VP_OFS,
    `PLL_FB_N_OFS,
    `PLL_OSC_CTRL_OFS,
    `SERIALIZER_EMPH_OFS,
    `TRIGGER_OUT_OFS,
    `PLL_PIN_OVR_OFS,
    `OSC_FREQ_ADJ_OFS,
    `PLL_CAL_RESET_OFS,
    `OSC_CAL_CTRL_OFS,
    `OSC_CAL_STATUS_OFS,
    `CAL_ENABLE_OFS,
    `CAL_SETUP_FIRST_OFS,
    `CAL_SETUP_SECOND_OFS,
    `CAL_AVERAGING_OFS,
    `CAL_PROGRESS_OFS,
    `CAL_PIN_SETUP_OFS,
    `CAL_SOFT_TRIGGER_OFS,
    `CAL_BG_LOW_POWER_OFS,
    `GAIN_DAC_ADJ_OFS,
    `BANDGAP_ADJ_OFS,
    `TERM_ADJ_A_OFS,
    `TERM_ADJ_B_OFS,
    `TERM_ADJ_C_OFS,
    `TERM_ADJ_D_OFS,
    `CONV_SRC_DELAY_OFS,
    `SEL_DELAY_CAL_OFS,
    `CONV_DITHER_OFS,
    `LOW_BIT_OUT_OFS,
    `LINK_SUBSYS_EN_OFS
  };

  // Address to slot: bit 6 flags a hit, bits 5:0 give the slot
  function automatic logic [6:0] slot_of(input reg_addr_t a);
    logic [6:0] r;
    r = 7'h00;
    for (int i = 0; i < `SLOT_COUNT; i++) begin
      if (a == SLOT_OFS[i]) begin
        r = {1'b1, 6'(i)};
      end
    end
    return r;
  endfunction

  // ==========================================================
  // Edge detection and address stepping
  // ==========================================================
  // Pins are synchronous to mclk_i, so one stored copy of sclk suffices
  assign cs_hi_w     = pins_i.port_select_low_n;
  assign rise_w      = !cs_hi_w && pins_i.sclk && !st_q.sclk;
  assign fall_w      = !cs_hi_w && !pins_i.sclk && st_q.sclk;
  assign byte_done_w = rise_w && (st_q.phase == PH_DATA) && (st_q.cnt == `DATA_LAST);
  assign dir_up_w    = bytes_w[`SLOT_SETUP][`DIR_BIT];
  assign hold_w      = bytes_w[`SLOT_USER][`HOLD_BIT];
  assign hdr_w       = {st_q.head, pins_i.sdi};

  // Hold wins over direction; the address wraps within 15 bits
  always_comb begin
    if (hold_w) begin
      next_addr_w = st_q.addr;
    end else if (dir_up_w) begin
      next_addr_w = st_q.addr + 15'd1;
    end else begin
      next_addr_w = st_q.addr - 15'd1;
    end
  end

  // ==========================================================
  // Register decode, write and read
  // ==========================================================
  assign dec_w     = slot_of(st_q.addr);
  assign wr_idx_w  = dec_w[5:0];
  assign wr_data_w = {st_q.rx, pins_i.sdi};

  // Only a complete write byte to a writable mapped slot is stored
  assign wr_en_w = byte_done_w && !st_q.rw && dec_w[6] && !RO_MASK[wr_idx_w];

  // Read mux; unmapped addresses read as zero
  always_comb begin
    rd_data_w = 8'h00;
    if (dec_w[6]) begin
      case (wr_idx_w)
        `SLOT_MAKER_LO: rd_data_w = MAKER_ID[7:0];
        `SLOT_MAKER_HI: rd_data_w = MAKER_ID[15:8];
        `SLOT_SYSREF:   rd_data_w = status_i.sysref_capture_window_status;
        `SLOT_OSC_CAL:  rd_data_w = status_i.osc_cal;
        `SLOT_CAL_PROG: rd_data_w = status_i.cal_progress;
        default:        rd_data_w = bytes_w[wr_idx_w];
      endcase
    end
  end

  byte_store u_store (
    .mclk_i  (mclk_i),
    .rst_i   (rst_i),
    .we_i    (wr_en_w),
    .slot_i  (wr_idx_w),
    .data_i  (wr_data_w),
    .bytes_o (bytes_w)
  );

  // ==========================================================
  // Frame sequencer
  // ==========================================================
  // Nothing here counts time, so a paused sclk simply waits
  always_comb begin
    st_d      = st_q;
    st_d.sclk = pins_i.sclk;
    if (cs_hi_w) begin
      // Select high ends the frame; a partial byte is dropped
      st_d.phase = PH_IDLE;
      st_d.cnt   = 4'd0;
      st_d.load  = 1'b0;
      st_d.pins  = '0;
    end else begin
      case (st_q.phase)
        PH_IDLE, PH_HEAD: begin
          // Leave idle only on a real edge, so a stopped clock moves nothing
          if (rise_w) begin
            st_d.phase = PH_HEAD;
            st_d.head = hdr_w[14:0];
            st_d.cnt  = st_q.cnt + 4'd1;
            if (st_q.cnt == `HEAD_LAST) begin
              st_d.rw    = hdr_w[15];
              st_d.addr  = hdr_w[14:0];
              st_d.phase = PH_DATA;
              st_d.cnt   = 4'd0;
              st_d.load  = 1'b1;
            end
          end
        end
        PH_DATA: begin
          // Read bits leave on the falling edge, ready for the next rise
          if (fall_w && st_q.rw) begin
            st_d.pins.sdo_oe = 1'b1;
            st_d.load        = 1'b0;
            if (st_q.load) begin
              {st_d.pins.sdo, st_d.tx} = rd_data_w;
            end else begin
              {st_d.pins.sdo, st_d.tx} = {st_q.tx, 1'b0};
            end
          end
          if (rise_w) begin
            st_d.rx  = wr_data_w[6:0];
            st_d.cnt = st_q.cnt + 4'd1;
            if (byte_done_w) begin
              st_d.cnt  = 4'd0;
              st_d.addr = next_addr_w;
              st_d.load = 1'b1;
            end
          end
        end
        default: begin
          st_d.phase = PH_IDLE;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign pins_o = st_q.pins;
  assign cfg_o  = bytes_w;

  // ==========================================================
  // Checks
  // ==========================================================
  property p_select_high_quiet;
    @(posedge mclk_i) disable iff (rst_i)
    cs_hi_w |=> (!pins_o.sdo_oe && st_q.phase == PH_IDLE);
  endproperty
  a_select_high_quiet: assert property (p_select_high_quiet)
    else $error("data out driven or frame alive after select high");

  property p_write_quiet;
    @(posedge mclk_i) disable iff (rst_i)
    (st_q.phase == PH_DATA && !st_q.rw) |-> !pins_o.sdo_oe;
  endproperty
  a_write_quiet: assert property (p_write_quiet)
    else $error("data out driven during a write");

  property p_head_quiet;
    @(posedge mclk_i) disable iff (rst_i)
    (st_q.phase != PH_DATA) |-> !pins_o.sdo_oe;
  endproperty
  a_head_quiet: assert property (p_head_quiet)
    else $error("data out driven during flag or address");

  property p_sdo_on_fall;
    @(posedge mclk_i) disable iff (rst_i)
    ($changed(pins_o.sdo) && !$past(cs_hi_w)) |-> $past(fall_w);
  endproperty
  a_sdo_on_fall: assert property (p_sdo_on_fall)
    else $error("data out moved without a falling clock edge");

  property p_count_on_rise;
    @(posedge mclk_i) disable iff (rst_i)
    ($changed(st_q.cnt) && !$past(cs_hi_w)) |-> $past(rise_w);
  endproperty
  a_count_on_rise: assert property (p_count_on_rise)
    else $error("bit count moved without a rising clock edge");

  property p_head_length;
    @(posedge mclk_i) disable iff (rst_i)
    (st_q.phase == PH_DATA && $past(st_q.phase) != PH_DATA)
      |-> ($past(st_q.cnt) == 4'd15 && $past(rise_w));
  endproperty
  a_head_length: assert property (p_head_length)
    else $error("data phase entered before sixteen header bits");

  property p_header_fields;
    @(posedge mclk_i) disable iff (rst_i)
    (st_q.phase == PH_DATA && $past(st_q.phase) != PH_DATA)
      |-> ({st_q.rw, st_q.addr} == $past(hdr_w));
  endproperty
  a_header_fields: assert property (p_header_fields)
    else $error("flag or address not taken from the header bits");

  property p_write_stores;
    @(posedge mclk_i) disable iff (rst_i)
    wr_en_w |=> (bytes_w[$past(wr_idx_w)] == $past(wr_data_w));
  endproperty
  a_write_stores: assert property (p_write_stores)
    else $error("written byte not found in the register");

  property p_read_no_write;
    @(posedge mclk_i) disable iff (rst_i)
    (byte_done_w && st_q.rw) |=> $stable(bytes_w);
  endproperty
  a_read_no_write: assert property (p_read_no_write)
    else $error("read frame changed a register");

  property p_step_up;
    @(posedge mclk_i) disable iff (rst_i)
    (byte_done_w && !hold_w && dir_up_w) |=> (st_q.addr == $past(st_q.addr) + 15'd1);
  endproperty
  a_step_up: assert property (p_step_up)
    else $error("address did not step up after a byte");

  property p_step_down;
    @(posedge mclk_i) disable iff (rst_i)
    (byte_done_w && !hold_w && !dir_up_w) |=> (st_q.addr == $past(st_q.addr) - 15'd1);
  endproperty
  a_step_down: assert property (p_step_down)
    else $error("address did not step down after a byte");

  property p_hold;
    @(posedge mclk_i) disable iff (rst_i)
    (byte_done_w && hold_w) |=> $stable(st_q.addr);
  endproperty
  a_hold: assert property (p_hold)
    else $error("address moved while held");

  property p_stream_on;
    @(posedge mclk_i) disable iff (rst_i)
    byte_done_w |=> (st_q.phase == PH_DATA && st_q.cnt == 4'd0);
  endproperty
  a_stream_on: assert property (p_stream_on)
    else $error("frame did not continue into the next byte");

  property p_stopped_clock;
    @(posedge mclk_i) disable iff (rst_i)
    (!cs_hi_w && !rise_w && !fall_w)
      |=> ($stable(st_q.phase) && $stable(st_q.cnt) && $stable(st_q.addr));
  endproperty
  a_stopped_clock: assert property (p_stopped_clock)
    else $error("frame state moved with the serial clock still");

  property p_cut_frame;
    @(posedge mclk_i) disable iff (rst_i)
    (cs_hi_w && st_q.phase == PH_DATA) |=> $stable(bytes_w);
  endproperty
  a_cut_frame: assert property (p_cut_frame)
    else $error("partial byte reached a register");

endmodule

/* File: tb/serial_host_model.sv */
`timescale 1ns/100ps

// ==========================================================
// Host controller model on the serial pins
// ==========================================================
module serial_host_model
  import serial_register_access_port_pkg::*;
(
  // Clock
  input  wire logic        mclk_i,
  // Serial pins
  output serial_in_s       pins_o,
  input  wire logic        sdo_i,
  input  wire logic        sdo_oe_i,
  // Captured read bytes
  output byte_t            rd_byte_o,
  output logic             rd_valid_o,
  output logic             oe_bad_o
);
  byte_t wdat [0:3];

  // Idle: deselected, clock parked low
  initial begin
    pins_o     = '{sclk: 1'b0, sdi: 1'b0, port_select_low_n: 1'b1};
    rd_byte_o  = 8'h00;
    rd_valid_o = 1'b0;
    oe_bad_o   = 1'b0;
  end

  // One bit: low phase of three cycles so the output has settled
  task automatic shift_bit(input logic v, input logic chk_oe, output logic s);
    @(negedge mclk_i);
    pins_o.sclk = 1'b0;
    pins_o.sdi  = v;
    repeat (3) @(negedge mclk_i);
    pins_o.sclk = 1'b1;
    s = sdo_i;
    if (chk_oe && sdo_oe_i !== 1'b0) begin
      oe_bad_o = 1'b1;
    end
    @(negedge mclk_i);
  endtask

  // Whole frame; cut>0 drops select after that many data bits
  task automatic xfer(input logic rd, input reg_addr_t a, input int nb, input int cut);
    logic [15:0] hd;
    logic        s;
    logic        v;
    byte_t       b;
    hd = {rd, a};
    b  = 8'h00;
    @(negedge mclk_i);
    pins_o.port_select_low_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      shift_bit(hd[i], 1'b1, s);
    end
    for (int j = 0; j < nb * 8 && (cut == 0 || j < cut); j++) begin
      // Read data bits on the input are junk on purpose
      v = rd ? 1'($urandom) : wdat[j / 8][7 - (j % 8)];
      shift_bit(v, !rd, s);
      b = {b[6:0], s};
      if (rd && (j % 8) == 7) begin
        rd_byte_o  = b;
        rd_valid_o = 1'b1;
        @(negedge mclk_i);
        rd_valid_o = 1'b0;
      end
    end
    @(negedge mclk_i);
    pins_o.port_select_low_n = 1'b1;
    pins_o.sclk = 1'b0;
    pins_o.sdi  = ~pins_o.sdi;  // Released data keeps moving
    repeat (2) @(negedge mclk_i);
  endtask
endmodule

/* File: tb/serial_register_access_port_tb_top.sv */
`timescale 1ns/100ps

// ==========================================================
// Testbench top
// ==========================================================
module serial_register_access_port_tb_top
  import serial_register_access_port_pkg::*;
;
  localparam logic [15:0] MAKER = 16'h1e2d;  // Arbitrary value

  logic        mclk_i;
  logic        rst_i;
  serial_in_s  pins;
  serial_out_s pout;
  ro_status_s  status;
  slot_bytes_t cfg;
  wire logic   sdo_w;
  byte_t       rd_byte;
  logic        rd_valid;
  logic        oe_bad;
  byte_t       exp_q [$];
  int          fail_count;
  int          cmp_count;
  byte_t       d;
  byte_t       sw [0:2];
  reg_addr_t   ra [0:7] = '{15'h000, 15'h029, 15'h030, 15'h031, 15'h037, 15'h06e, 15'h200, 15'h003};
  byte_t       rv [0:7] = '{8'h30, 8'h80, 8'h00, 8'ha0, 8'h4b, 8'h88, 8'h01, 8'h00};

  // Resolved data-out wire, floats when not driven
  assign sdo_w = pout.sdo_oe ? pout.sdo : 1'bz;

  serial_register_access_port #(.MAKER_ID(MAKER)) DUT (
    .mclk_i   (mclk_i),
    .rst_i    (rst_i),
    .pins_i   (pins),
    .pins_o   (pout),
    .status_i (status),
    .cfg_o    (cfg)
  );

  serial_host_model u_host (
    .mclk_i     (mclk_i),
    .pins_o     (pins),
    .sdo_i      (sdo_w),
    .sdo_oe_i   (pout.sdo_oe),
    .rd_byte_o  (rd_byte),
    .rd_valid_o (rd_valid),
    .oe_bad_o   (oe_bad)
  );

  always #5 mclk_i = ~mclk_i;

  task automatic check(input string nm, input byte_t seen, input byte_t exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic rd(input reg_addr_t a, input byte_t e);
    exp_q.push_back(e);
    u_host.xfer(1'b1, a, 1, 0);
  endtask

  task automatic wr(input reg_addr_t a, input byte_t v);
    u_host.wdat[0] = v;
    u_host.xfer(1'b0, a, 1, 0);
  endtask

  // Scoreboard: oldest expectation against each captured byte
  always @(posedge mclk_i) begin
    if (rd_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        check("unexpected read bytes", 8'h01, 8'h00);
      end else begin
        check("read byte", rd_byte, exp_q.pop_front());
      end
    end
  end

  // Watchdog, far beyond the expected run
  initial begin
    repeat (60000) @(posedge mclk_i);
    fail_count++;
    $display("MISMATCH watchdog expected done seen timeout");
    stop_test();
  end

  // Main sequence
  initial begin
    mclk_i     = 1'b0;
    rst_i      = 1'b1;
    fail_count = 0;
    cmp_count  = 0;
    void'($urandom(32'hc5f38124));
    // Status stays fixed: no calibration runs while frames are sent
    status = ro_status_s'(24'($urandom));
    repeat (12) @(posedge mclk_i);
    @(negedge mclk_i);
    rst_i = 1'b0;
    // Reset image, wide register low byte first
    for (int i = 0; i < 8; i++) begin
      rd(ra[i], rv[i]);
    end
    rd(15'h00c, MAKER[7:0]);
    rd(15'h00d, MAKER[15:8]);
    rd(15'h02c, status.sysref_capture_window_status);
    rd(15'h05e, status.osc_cal);
    rd(15'h06a, status.cal_progress);
    // Single write and read back; the byte must also reach cfg_o
    d = 8'($urandom);
    wr(15'h02a, d);
    rd(15'h02a, d);
    check("config slot", cfg[6], d);
    // Unlisted addresses read as zero; a write to the read-only 15'h00c is ignored
    rd(15'h4029, 8'h00);
    rd(15'h029, 8'h80);
    wr(15'h00c, ~MAKER[7:0]);
    rd(15'h00c, MAKER[7:0]);
    rd(15'h004, 8'h00);
    // Ascending stream write then stream read
    for (int i = 0; i < 3; i++) begin
      sw[i] = 8'($urandom);
      u_host.wdat[i] = sw[i];
    end
    u_host.xfer(1'b0, 15'h03b, 3, 0);
    for (int i = 0; i < 3; i++) begin
      exp_q.push_back(sw[i]);
    end
    u_host.xfer(1'b1, 15'h03b, 3, 0);
    // Descending stream read
    wr(15'h000, 8'h10);
    exp_q.push_back(8'h20);
    exp_q.push_back(sw[2]);
    exp_q.push_back(sw[1]);
    u_host.xfer(1'b1, 15'h03e, 3, 0);
    wr(15'h000, 8'h30);
    // Cut frames: partial bytes dropped, whole ones kept
    u_host.wdat[0] = 8'hc3;
    u_host.xfer(1'b0, 15'h057, 1, 5);
    rd(15'h057, 8'h00);
    u_host.wdat[1] = 8'h96;
    u_host.xfer(1'b0, 15'h058, 2, 12);
    rd(15'h058, 8'hc3);
    rd(15'h059, 8'h00);
    // Address hold: both bytes land on one register
    wr(15'h010, 8'h01);
    u_host.wdat[0] = 8'($urandom);
    u_host.wdat[1] = 8'($urandom);
    u_host.xfer(1'b0, 15'h061, 2, 0);
    rd(15'h061, u_host.wdat[1]);
    rd(15'h062, 8'h01);
    check("config slot", cfg[24], u_host.wdat[1]);
    check("write frame output enable", {7'h00, oe_bad}, 8'h00);
    check("pending reads", 8'(exp_q.size()), 8'h00);
    stop_test();
  end
endmodule
